// file: core/err_pulse_sync.v
// Two-flop synchroniser with rising-edge pulse for one event input.
// Assumes the input is a level or pulse at least two clocks wide.
module err_pulse_sync (
  // Clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // Asynchronous event in, synchronous pulse out
  input wire async_i,
  output wire pulse_o
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // First flop feeds only the second; the edge looks at later stages
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pulse_o = sync_reg & ~last_reg;
endmodule

// file: core/err_report.v
// Error-report register bank for a serial display video receiver.
// Assumes detector pulses come from other logic or pins and are
// synchronised here; registers sit on a plain 8-bit strobe port.
// The strobes come from logic on the same clock and are used as-is;
// only the event lines are treated as asynchronous.
`include "err_report_defines.vh"

// Register map, byte offsets:
//   22h physical-layer error enables, 23h protocol error enables,
//   24h configuration, 28h error flags, 29h error count,
//   2Eh interrupt status, 2Fh interrupt mask.
// Every other offset reads zero and ignores writes.

module err_report #(
  parameter CLASSES = `ERR_CLASSES
) (
  // Clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Error class detect pulses: [7:0] phy order, [14:8] protocol order
  input wire [CLASSES-1:0] class_err_i,
  // Video FIFO, link buffer and missing end packet events
  input wire fifo_over_i,
  input wire fifo_under_i,
  input wire link_buffer_over_i,
  input wire missing_end_packet_i,
  // Error indication and interrupt
  output reg err_ind_o,
  output reg irq_o
);
  // Event vector: the error classes first, then the four single events
  localparam NEV = CLASSES + 4;
  // Positions of the single events above the error classes
  localparam IDX_OVER = CLASSES;
  localparam IDX_UNDER = CLASSES + 1;
  localparam IDX_LINK = CLASSES + 2;
  localparam IDX_END = CLASSES + 3;
  // Reset image of the protocol enable; its top bit is reserved and
  // not stored, so only the low seven bits are loaded
  localparam [7:0] PROT_RST = `PROTOCOL_ERROR_ENABLE_RST;

  // Software-visible enables and configuration
  reg [7:0] phy_error_enable_reg;
  reg [6:0] protocol_error_enable_reg;
  reg [7:0] config_reg;
  // Clear-on-read flags and their next value
  reg [7:0] receiver_error_flags_reg;
  reg [7:0] receiver_error_flags_next;
  // Clear-on-read error count and its next value
  reg [7:0] error_event_counter_reg;
  reg [7:0] error_event_counter_next;
  // Write-one-to-clear interrupt status and its mask
  reg [7:0] irq_status_reg;
  reg [7:0] irq_status_next;
  reg [7:0] irq_mask_reg;
  // Latched error for hold mode
  reg hold_latch_reg;
  // Read mux output, registered onto the port
  reg [7:0] rdata_next;

  // Raw and synchronised event lines
  wire [NEV-1:0] ev_async;
  wire [NEV-1:0] ev;
  // Error classes after synchronising, and their enables side by side
  wire [CLASSES-1:0] class_pulse;
  wire [CLASSES-1:0] class_enable;
  // Combined error event and the qualified missing-end event
  wire any_enabled;
  wire missing_end_event;
  // Reads of the two clear-on-read registers
  wire rd_flags;
  wire rd_count;
  // Interrupt set requests
  wire [7:0] irq_events;
  // Per-class pulses that survive their enable bit
  wire [CLASSES-1:0] class_hit;
  // One-cycle set requests, laid out like the flag register
  wire [7:0] flag_set;
  // Register write decodes, one per writable offset
  wire wr_phy;
  wire wr_prot;
  wire wr_cfg;
  wire wr_mask;
  wire wr_irq_clr;
  // Control bits taken out of the configuration register
  wire tolerate;
  wire hold_mode;
  // Counter has reached its ceiling and must not wrap
  wire count_full;

  // Every event crosses in from outside through its own synchroniser.
  // That costs three cycles of latency between a rising event line
  // and the flag update, which only diagnostics ever see.
  assign ev_async = {missing_end_packet_i, link_buffer_over_i,
    fifo_under_i, fifo_over_i, class_err_i};

  // One synchroniser per event; each turns a rising level into a
  // single-cycle pulse, so a long level counts once and a second
  // event needs the line to fall for at least one cycle first
  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi = gi + 1) begin : g_sync
      err_pulse_sync u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(ev_async[gi]),
        .pulse_o(ev[gi])
      );
    end
  endgenerate

  // Low part of the event vector carries the error classes, in the
  // same order as the two enable registers laid end to end
  assign class_pulse = ev[CLASSES-1:0];

  // Bit layout of both enables maps one to one onto the class inputs
  assign class_enable = {protocol_error_enable_reg, phy_error_enable_reg};
  // Each class is gated by its own enable bit; one loop keeps the
  // per-class logic uniform however many classes the parameter sets
  genvar ci;
  generate
    for (ci = 0; ci < CLASSES; ci = ci + 1) begin : g_class
      assign class_hit[ci] = class_pulse[ci] & class_enable[ci];
    end
  endgenerate

  // Any surviving class counts as one error event in this cycle
  assign any_enabled = |class_hit;

  // Tolerance on means the end-of-transmission check is silenced
  assign tolerate = config_reg[`CFG_TOLERATE_BIT];
  assign hold_mode = config_reg[`CFG_HOLD_BIT];
  assign missing_end_event = ev[IDX_END] & ~tolerate;

  // Read decodes for the two clear-on-read registers; the clear is
  // tied to the strobe, so a read that software discards still clears
  assign rd_flags = reg_rd_i &
    (reg_addr_i == `RECEIVER_ERROR_FLAGS_ADDR);
  assign rd_count = reg_rd_i &
    (reg_addr_i == `ERROR_EVENT_COUNTER_ADDR);

  // Write decodes; the flag and counter offsets have none, so writes
  // there fall through and change nothing
  assign wr_phy = reg_wr_i & (reg_addr_i == `PHY_ERROR_ENABLE_ADDR);
  assign wr_prot = reg_wr_i &
    (reg_addr_i == `PROTOCOL_ERROR_ENABLE_ADDR);
  assign wr_cfg = reg_wr_i & (reg_addr_i == `CONFIG_ADDR);
  assign wr_mask = reg_wr_i & (reg_addr_i == `IRQ_MASK_ADDR);
  assign wr_irq_clr = reg_wr_i & (reg_addr_i == `IRQ_STATUS_ADDR);

  // Set requests per flag bit; these same pulses feed the interrupt
  // status, so both registers always see exactly the same events
  assign flag_set[7] = 1'b0;
  assign flag_set[`FLAG_FIFO_OVER] = ev[IDX_OVER];
  assign flag_set[`FLAG_FIFO_UNDER] = ev[IDX_UNDER];
  assign flag_set[`FLAG_LINK_BUFFER] = ev[IDX_LINK];
  // No command mode, so these two are never raised
  assign flag_set[`FLAG_CMD_OVERRUN] = 1'b0;
  assign flag_set[`FLAG_MISSING_END] = missing_end_event;
  assign flag_set[`FLAG_READ_NO_TURNAROUND] = 1'b0;
  assign flag_set[`FLAG_ANY_ERROR] = any_enabled;

  // Clear on read, but a same-cycle event keeps its bit set; losing
  // an overflow that lands on the read would hide it for good.
  // Only the bits that are read get cleared, all of them at once,
  // since the whole register goes out in the one read.
  always @* begin
    if (rd_flags) begin
      receiver_error_flags_next = flag_set;
    end else begin
      receiver_error_flags_next = receiver_error_flags_reg | flag_set;
    end
    // Reserved and unsupported bits always read as zero
    receiver_error_flags_next[`FLAG_CMD_OVERRUN] = 1'b0;
    receiver_error_flags_next[`FLAG_READ_NO_TURNAROUND] = 1'b0;
    receiver_error_flags_next[7] = 1'b0;
  end

  // Ceiling of the eight-bit count
  assign count_full = (error_event_counter_reg == 8'hFF);

  // Software that wants an exact figure clears both enables before
  // reading, so no event can slip in between the read and the clear.
  // Counter saturates rather than wraps; a count arriving with the
  // read is kept as one so it is not lost
  always @* begin
    if (rd_count) begin
      error_event_counter_next = any_enabled ? 8'h01 : 8'h00;
    end else if (any_enabled && !count_full) begin
      error_event_counter_next = error_event_counter_reg + 8'h01;
    end else begin
      error_event_counter_next = error_event_counter_reg;
    end
  end

  // Interrupt events mirror the flag layout
  assign irq_events = flag_set;

  // Write one clears; a new event in the same cycle wins, so an event
  // that races the software acknowledge still raises the interrupt
  always @* begin
    if (wr_irq_clr) begin
      irq_status_next = (irq_status_reg & ~reg_wdata_i) | irq_events;
    end else begin
      irq_status_next = irq_status_reg | irq_events;
    end
  end

  // Read mux; unmapped offsets read zero. The mux is decoded from the
  // address alone, and the strobe only decides whether the result is
  // registered, which keeps the decode off the clear-on-read path.
  always @* begin
    case (reg_addr_i)
      `PHY_ERROR_ENABLE_ADDR: rdata_next = phy_error_enable_reg;
      `PROTOCOL_ERROR_ENABLE_ADDR: rdata_next = {1'b0,
        protocol_error_enable_reg};
      `CONFIG_ADDR: rdata_next = config_reg;
      `RECEIVER_ERROR_FLAGS_ADDR: rdata_next = receiver_error_flags_reg;
      `ERROR_EVENT_COUNTER_ADDR: rdata_next = error_event_counter_reg;
      `IRQ_STATUS_ADDR: rdata_next = irq_status_reg;
      `IRQ_MASK_ADDR: rdata_next = irq_mask_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Physical-layer enables; every class is reported out of reset
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phy_error_enable_reg <= `PHY_ERROR_ENABLE_RST;
    end else if (wr_phy) begin
      phy_error_enable_reg <= reg_wdata_i;
    end
  end

  // Protocol enables; bit 7 is reserved, not stored, and reads zero
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      protocol_error_enable_reg <= PROT_RST[6:0];
    end else if (wr_prot) begin
      protocol_error_enable_reg <= reg_wdata_i[6:0];
    end
  end

  // Configuration: only the tolerance and hold bits are kept
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      config_reg <= `CONFIG_RST;
    end else if (wr_cfg) begin
      config_reg <= {6'h00, reg_wdata_i[1:0]};
    end
  end

  // Interrupt mask; starts closed so nothing fires before setup
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_mask_reg <= 8'h00;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata_i;
    end
  end

  // Flags, counter and interrupt status advance every cycle
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      receiver_error_flags_reg <= 8'h00;
      error_event_counter_reg <= 8'h00;
      irq_status_reg <= 8'h00;
    end else begin
      receiver_error_flags_reg <= receiver_error_flags_next;
      error_event_counter_reg <= error_event_counter_next;
      irq_status_reg <= irq_status_next;
    end
  end

  // Read data stands for one cycle after the strobe and is zero
  // otherwise, so a bus that ORs several slaves needs no select
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Hold latch: set by any enabled error, dropped by a flag read.
  // A new error in the read cycle wins, like the flag itself.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hold_latch_reg <= 1'b0;
    end else if (any_enabled) begin
      hold_latch_reg <= 1'b1;
    end else if (rd_flags) begin
      hold_latch_reg <= 1'b0;
    end
  end

  // Indication: pulse per error, or latched until the flags are read.
  // The latch runs in both modes, so switching to hold mode shows
  // errors that arrived since the last flag read.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      err_ind_o <= 1'b0;
    end else if (hold_mode) begin
      err_ind_o <= any_enabled | (hold_latch_reg & ~rd_flags);
    end else begin
      err_ind_o <= any_enabled;
    end
  end

  // Interrupt level follows the next status so it rises with the flag
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end
endmodule

// file: core/err_report_defines.vh
// Constants for the receiver error-report register bank.
// Assumes an 8-bit register port with byte offsets as addresses.
`ifndef ERR_REPORT_DEFINES_VH
`define ERR_REPORT_DEFINES_VH

// Register offsets
`define PHY_ERROR_ENABLE_ADDR 8'h22
`define PROTOCOL_ERROR_ENABLE_ADDR 8'h23
`define CONFIG_ADDR 8'h24
`define RECEIVER_ERROR_FLAGS_ADDR 8'h28
`define ERROR_EVENT_COUNTER_ADDR 8'h29
`define IRQ_STATUS_ADDR 8'h2E
`define IRQ_MASK_ADDR 8'h2F

// Reset values
`define PHY_ERROR_ENABLE_RST 8'hFF
`define PROTOCOL_ERROR_ENABLE_RST 8'h7F
`define PROTOCOL_ERROR_ENABLE_MASK 8'h7F
`define CONFIG_RST 8'h00

// Status bit positions
`define FLAG_ANY_ERROR 0
`define FLAG_READ_NO_TURNAROUND 1
`define FLAG_MISSING_END 2
`define FLAG_CMD_OVERRUN 3
`define FLAG_LINK_BUFFER 4
`define FLAG_FIFO_UNDER 5
`define FLAG_FIFO_OVER 6

// Configuration bit positions
`define CFG_TOLERATE_BIT 0
`define CFG_HOLD_BIT 1

// Number of error classes: 8 phy, then 7 protocol
`define ERR_CLASSES 15
`endif

// file: dv/err_event_source.sv
// Far-side model: detectors and FIFOs raising event lines.
// Assumes one fire pulse per burst from the bench.
module err_event_source (
  input wire mclk_i,
  input wire fire_i,
  input wire [18:0] sel_i,
  output logic [18:0] ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_reg;
  initial ev_o = 19'h0;
  initial hold_reg = 2'h0;
  // Four cycles high, so the two-flop synchroniser cannot miss it
  always @(posedge mclk_i)
    if (fire_i) begin
      ev_o <= sel_i;
      hold_reg <= 2'h3;
    end else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
    else ev_o <= 19'h0;
endmodule

// file: dv/err_report_chk.sv
// Port checker for the error-report bank.
// Assumes event inputs stay low while reset is held.
module err_report_chk #(parameter CLASSES = 15) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [CLASSES-1:0] class_err_i,
  input wire fifo_over_i,
  input wire fifo_under_i,
  input wire link_buffer_over_i,
  input wire missing_end_packet_i,
  input wire err_ind_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] age_reg;
  wire ev_any = |class_err_i | fifo_over_i | fifo_under_i
    | link_buffer_over_i | missing_end_packet_i;
  wire rd28 = reg_rd_i && reg_addr_i == 8'h28;
  wire rd29 = reg_rd_i && reg_addr_i == 8'h29;
  wire mapped = reg_addr_i inside {8'h22, 8'h23, 8'h24, 8'h28, 8'h29,
    8'h2E, 8'h2F};
  // Quiet age, so clear-on-read checks skip events still in flight
  always @(posedge mclk_i)
    if (sys_rst_i || ev_any) age_reg <= 8'h00;
    else if (age_reg != 8'hFF) age_reg <= age_reg + 8'h01;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RSVD_BITS: assert property (
    rd28 |=> (reg_rdata_o & 8'h8A) == 8'h00) else $error("reserved set");
  AST_FLAGS_CLEAR: assert property (
    (rd28 && age_reg > 8'h06) ##1 rd28 |=> reg_rdata_o == 8'h00)
    else $error("flags not cleared by read");
  AST_CNT_CLEAR: assert property (
    (rd29 && age_reg > 8'h06) ##1 rd29 |=> reg_rdata_o == 8'h00)
    else $error("count not cleared by read");
  AST_ERR_CAUSE: assert property (
    $rose(err_ind_o) |-> age_reg <= 8'h06) else $error("stray err_ind");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> age_reg <= 8'h06
    || $past(reg_wr_i) || $past(reg_wr_i, 2)) else $error("stray irq");
  AST_UNMAPPED: assert property (
    reg_rd_i && !mapped |=> reg_rdata_o == 8'h00) else $error("unmapped");
  AST_RDATA_IDLE: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata not idle");
  AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst_i |=>
    !err_ind_o && !irq_o && reg_rdata_o == 8'h00) else $error("reset");
  cover property ($rose(err_ind_o));
  cover property ($rose(irq_o));
  cover property (rd29 ##1 reg_rdata_o != 8'h00);
endmodule
bind err_report err_report_chk #(.CLASSES(CLASSES)) err_report_chk_inst (
  .mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .class_err_i, .fifo_over_i, .fifo_under_i,
  .link_buffer_over_i, .missing_end_packet_i, .err_ind_o, .irq_o);

// file: dv/err_report_test.sv
// Self-checking bench for the error-report bank.
// Assumes the event model and the bound checker are compiled first.
module err_report_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fire = 1'b0;
  logic [18:0] sel = 19'h0;
  logic [14:0] m;
  logic [7:0] fx [4] = '{8'h40, 8'h20, 8'h10, 8'h04};
  wire [18:0] ev;
  wire [7:0] reg_rdata_o;
  wire err_ind_o;
  wire irq_o;
  int n_fail = 0;
  int tests_run = 0;
  always #2.5 mclk_i = ~mclk_i;
  err_event_source err_event_source_inst (.mclk_i, .fire_i(fire),
    .sel_i(sel), .ev_o(ev));
  err_report err_report_inst (.mclk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .class_err_i(ev[14:0]), .fifo_over_i(ev[15]), .fifo_under_i(ev[16]),
    .link_buffer_over_i(ev[17]), .missing_end_packet_i(ev[18]),
    .err_ind_o, .irq_o);
  task automatic chk(input string w, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkb(input string w, input logic e, g);
    chk(w, {7'h0, e}, {7'h0, g});
  endtask
  // Strobes drop at the next edge, so calls run back to back
  task automatic wr(input logic [7:0] a, d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic hit(input logic [18:0] s);
    fire <= 1'b1;
    sel <= s;
    @(posedge mclk_i);
    fire <= 1'b0;
    cyc(8);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Run is near 530 cycles; eleven times that means a hang
  initial begin
    repeat (6000) @(posedge mclk_i);
    n_fail++;
    conclude;
  end
  initial begin
    cyc(20);
    sys_rst_i <= 1'b0;
    // Reset values, reserved bit, unmapped place
    rd(8'h22, 8'hFF);
    rd(8'h23, 8'h7F);
    rd(8'h2F, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h7F);
    // Each class passes only through its own enable bit
    for (int k = 0; k < 15; k++) begin
      m = 15'h1 << k;
      wr(8'h22, ~m[7:0]);
      wr(8'h23, {1'b0, ~m[14:8]});
      hit({4'h0, m});
      rd(8'h28, 8'h00);
      rd(8'h29, 8'h00);
      wr(8'h22, m[7:0]);
      wr(8'h23, {1'b0, m[14:8]});
      hit({4'h0, m});
      chkb("err_ind", 1'b0, err_ind_o);
      rd(8'h28, 8'h01);
      rd(8'h29, 8'h01);
    end
    // Three events, counting stopped before the read
    wr(8'h22, 8'h01);
    repeat (3) hit(19'h1);
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h00);
    rd(8'h29, 8'h03);
    rd(8'h29, 8'h00);
    rd(8'h28, 8'h01);
    // FIFO, link buffer and missing end flags
    for (int k = 0; k < 4; k++) begin
      hit(19'h8000 << k);
      rd(8'h28, fx[k]);
      rd(8'h28, 8'h00);
    end
    wr(8'h24, 8'h01);
    hit(19'h40000);
    rd(8'h28, 8'h00);
    // Hold mode; interrupt raised, masked, cleared
    wr(8'h22, 8'hFF);
    wr(8'h24, 8'h02);
    wr(8'h2E, 8'hFF);
    wr(8'h2F, 8'h01);
    chkb("irq", 1'b0, irq_o);
    hit(19'h1);
    chkb("err_ind", 1'b1, err_ind_o);
    chkb("irq", 1'b1, irq_o);
    wr(8'h2F, 8'h00);
    cyc(2);
    chkb("irq", 1'b0, irq_o);
    wr(8'h2F, 8'h01);
    cyc(2);
    chkb("irq", 1'b1, irq_o);
    wr(8'h2E, 8'h01);
    cyc(2);
    chkb("irq", 1'b0, irq_o);
    rd(8'h28, 8'h01);
    cyc(2);
    chkb("err_ind", 1'b0, err_ind_o);
    conclude;
  end
endmodule
